// file: design/srsa_regs.svh
`ifndef SRSA_REGS_SVH
`define SRSA_REGS_SVH
// Register word indices; byte address is four times the index
`define SRSA_IDX_DIVIDER 8'h12
`define SRSA_IDX_AVGCFG 8'h15
`define SRSA_IDX_OFFSET_A1 8'h18
// Own status and result registers
`define SRSA_IDX_SUM_A 8'h70
`define SRSA_IDX_SUM_B 8'h78
`define SRSA_IDX_AVG_A 8'h64
`define SRSA_IDX_AVG_B 8'h68
`define SRSA_IDX_BUF 8'h60
`define SRSA_IDX_STATUS 8'h40
// Reset values
`define SRSA_DIVIDER_RST 16'h0028
`define SRSA_AVG_B_RST 3'h6
`define SRSA_AVG_A_RST 3'h0
`define SRSA_OFFSET_RST 16'h2000
// Field positions
`define SRSA_AVG_B_HI 10
`define SRSA_AVG_B_LO 8
`define SRSA_AVG_A_HI 6
`define SRSA_AVG_A_LO 4
// Timebase: 32 kHz tick from 100 MHz clock
`define SRSA_CLK_HZ 100000000
`define SRSA_TB_HZ 32000
`define SRSA_TB_CYCLES (`SRSA_CLK_HZ / `SRSA_TB_HZ)
`define SRSA_TB_MULT 4
`endif

// file: design/srsa_pkg.sv
package srsa_pkg;
  typedef struct packed {
    logic [26:0] sum;
    logic [15:0] avg;
  } srsa_result_s;
  typedef enum logic [1:0] {
    SRSA_IDLE = 2'b01,
    SRSA_ACC = 2'b10
  } srsa_state_e;
endpackage

// file: design/srsa_slot_avg.sv
`timescale 1ns/1ps
`default_nettype none
module srsa_slot_avg
  import srsa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [2:0] avg_code,
  input wire logic [15:0] offset,
  input wire logic sample_valid,
  input wire logic [15:0] sample_raw,
  output logic result_valid,
  output srsa_result_s result
);
  logic [26:0] acc_q, acc_d;
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] code_q, code_d;
  logic rv_q, rv_d;
  srsa_result_s res_q, res_d;
  srsa_state_e st_q, st_d;
  logic [26:0] term;
  logic [7:0] need;

  always_comb begin
    term = {11'h000, sample_raw - offset};
    need = 8'(9'h001 << avg_code);
    acc_d = acc_q;
    cnt_d = cnt_q;
    code_d = avg_code;
    rv_d = 1'b0;
    res_d = res_q;
    st_d = st_q;
    case (st_q)
      SRSA_IDLE: begin
        acc_d = 27'h0000000;
        cnt_d = 8'h00;
        st_d = SRSA_ACC;
      end
      SRSA_ACC: begin
        if (code_q != avg_code) begin
          acc_d = 27'h0000000;
          cnt_d = 8'h00;
        end else if (sample_valid) begin
          if (cnt_q + 8'h01 == need) begin
            res_d.sum = acc_q + term;
            res_d.avg = 16'((acc_q + term) >> avg_code);
            rv_d = 1'b1;
            acc_d = 27'h0000000;
            cnt_d = 8'h00;
          end else begin
            acc_d = acc_q + term;
            cnt_d = cnt_q + 8'h01;
          end
        end
      end
      default: st_d = SRSA_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 27'h0000000;
      cnt_q <= 8'h00;
      code_q <= 3'h0;
      rv_q <= 1'b0;
      res_q <= '0;
      st_q <= SRSA_IDLE;
    end else begin
      acc_q <= acc_d;
      cnt_q <= cnt_d;
      code_q <= code_d;
      rv_q <= rv_d;
      res_q <= res_d;
      st_q <= st_d;
    end
  end

  assign result_valid = rv_q;
  assign result = res_q;
endmodule
`default_nettype wire

// file: design/srsa_top.sv
// What this block does
// - Sample rate is 32 kHz over four times divider
// - Slot B sums 2^n samples, code reset 6
// - Group sum goes to wide sum words
// - Group average goes to 16-bit words, buffer
// - One result per completed group of samples
// - Slot A averages alike, code reset 0
// - Subtract slot A channel 1 offset first
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "srsa_regs.svh"
module srsa_top
  import srsa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic slot_a_valid,
  input wire logic [15:0] slot_a_raw,
  input wire logic slot_b_valid,
  input wire logic [15:0] slot_b_raw,
  output logic sample_strobe,
  output logic slot_a_result_valid,
  output srsa_result_s slot_a_result,
  output logic slot_b_result_valid,
  output srsa_result_s slot_b_result
);
  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [15:0] div_q, div_d, cfg_q, cfg_d, off_q, off_d;
  logic [15:0] buf_q, buf_d;
  logic [1:0] seen_q, seen_d;
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0] awi_q, awi_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [15:0] rdword;
  logic rdhit;
  logic [31:0] wdat_q, wdat_d;

  function automatic logic [7:0] word_idx(input logic [31:0] a);
    word_idx = a[9:2];
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] o,
    input logic [31:0] d, input logic [3:0] s);
    merge = {s[1] ? d[15:8] : o[15:8], s[0] ? d[7:0] : o[7:0]};
  endfunction

  always_comb begin
    rdhit = 1'b1;
    case (word_idx(s_axi_araddr))
      `SRSA_IDX_DIVIDER: rdword = div_q;
      `SRSA_IDX_AVGCFG: rdword = cfg_q;
      `SRSA_IDX_OFFSET_A1: rdword = off_q;
      `SRSA_IDX_BUF: rdword = buf_q;
      `SRSA_IDX_AVG_A: rdword = slot_a_result.avg;
      `SRSA_IDX_AVG_B: rdword = slot_b_result.avg;
      `SRSA_IDX_SUM_A: rdword = slot_a_result.sum[15:0];
      `SRSA_IDX_SUM_A + 8'h04: rdword = {5'h00, slot_a_result.sum[26:16]};
      `SRSA_IDX_SUM_B: rdword = slot_b_result.sum[15:0];
      `SRSA_IDX_SUM_B + 8'h04: rdword = {5'h00, slot_b_result.sum[26:16]};
      `SRSA_IDX_STATUS: rdword = {14'h0000, seen_q};
      default: begin
        rdword = 16'h0000;
        rdhit = 1'b0;
      end
    endcase
  end

  assign s_axi_awready = !aw_q && !b_q;
  assign s_axi_wready = !w_q && !b_q;
  assign s_axi_arready = !r_q;

  always_comb begin
    div_d = div_q;
    cfg_d = cfg_q;
    off_d = off_q;
    aw_d = aw_q;
    w_d = w_q;
    b_d = b_q;
    r_d = r_q;
    awi_d = awi_q;
    wd_d = wd_q;
    rd_d = rd_q;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    buf_d = buf_q;
    seen_d = seen_q;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_d = 1'b1;
      awi_d = word_idx(s_axi_awaddr);
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_d = 1'b1;
      wd_d = {s_axi_wdata[31:4], s_axi_wstrb};
      wd_d[3:0] = s_axi_wstrb;
    end
    if (aw_q && w_q) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      bresp_d = 2'b00;
      case (awi_q)
        `SRSA_IDX_DIVIDER: div_d = merge(div_q, wdat_q, wd_q[3:0]);
        `SRSA_IDX_AVGCFG: cfg_d = merge(cfg_q, wdat_q, wd_q[3:0]);
        `SRSA_IDX_OFFSET_A1: off_d = merge(off_q, wdat_q, wd_q[3:0]);
        default: bresp_d = 2'b10;
      endcase
    end
    if (b_q && s_axi_bready) b_d = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      r_d = 1'b1;
      rd_d = {16'h0000, rdword};
      rresp_d = rdhit ? 2'b00 : 2'b10;
    end else if (r_q && s_axi_rready) begin
      r_d = 1'b0;
    end
    // Latest average of either slot lands in the buffer word; slot A wins when both arrive in one cycle
    if (slot_b_result_valid) buf_d = slot_b_result.avg;
    if (slot_a_result_valid) buf_d = slot_a_result.avg;
    if (slot_a_result_valid) seen_d[0] = 1'b1;
    if (slot_b_result_valid) seen_d[1] = 1'b1;
  end

  always_comb begin
    wdat_d = wdat_q;
    if (s_axi_wvalid && s_axi_wready) wdat_d = s_axi_wdata;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= `SRSA_DIVIDER_RST;
      cfg_q <= {5'h00, `SRSA_AVG_B_RST, 1'b0, `SRSA_AVG_A_RST, 4'h0};
      off_q <= `SRSA_OFFSET_RST;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      b_q <= 1'b0;
      r_q <= 1'b0;
      awi_q <= 8'h00;
      wd_q <= 32'h00000000;
      wdat_q <= 32'h00000000;
      rd_q <= 32'h00000000;
      bresp_q <= 2'b00;
      rresp_q <= 2'b00;
      buf_q <= 16'h0000;
      seen_q <= 2'b00;
    end else begin
      div_q <= div_d;
      cfg_q <= cfg_d;
      off_q <= off_d;
      aw_q <= aw_d;
      w_q <= w_d;
      b_q <= b_d;
      r_q <= r_d;
      awi_q <= awi_d;
      wd_q <= wd_d;
      wdat_q <= wdat_d;
      rd_q <= rd_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      buf_q <= buf_d;
      seen_q <= seen_d;
    end
  end

  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // Sample rate timebase
  // ----------------------------------------
  // 32 kHz tick, then divide by four times the divider value
  logic [15:0] tb_q, tb_d;
  logic [17:0] sc_q, sc_d;
  logic st_q, st_d;
  logic tick;
  assign tick = (tb_q == 16'(`SRSA_TB_CYCLES - 1));
  always_comb begin
    tb_d = tick ? 16'h0000 : tb_q + 16'h0001;
    sc_d = sc_q;
    st_d = 1'b0;
    if (tick) begin
      // Zero divider stops sampling instead of running flat out
      if (div_q != 16'h0000 &&
          sc_q + 18'h00001 >= 18'(div_q) * 18'(`SRSA_TB_MULT)) begin
        sc_d = 18'h00000;
        st_d = 1'b1;
      end else begin
        sc_d = sc_q + 18'h00001;
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tb_q <= 16'h0000;
      sc_q <= 18'h00000;
      st_q <= 1'b0;
    end else begin
      tb_q <= tb_d;
      sc_q <= sc_d;
      st_q <= st_d;
    end
  end
  assign sample_strobe = st_q;

  // ----------------------------------------
  // Slot averagers
  // ----------------------------------------
  // Slot B has no offset register here, so nothing is subtracted
  srsa_slot_avg u_slot_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .avg_code(cfg_q[`SRSA_AVG_A_HI:`SRSA_AVG_A_LO]),
    .offset(off_q),
    .sample_valid(slot_a_valid),
    .sample_raw(slot_a_raw),
    .result_valid(slot_a_result_valid),
    .result(slot_a_result)
  );
  srsa_slot_avg u_slot_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .avg_code(cfg_q[`SRSA_AVG_B_HI:`SRSA_AVG_B_LO]),
    .offset(16'h0000),
    .sample_valid(slot_b_valid),
    .sample_raw(slot_b_raw),
    .result_valid(slot_b_result_valid),
    .result(slot_b_result)
  );
endmodule
`default_nettype wire

// file: test/srsa_adc_model.sv
`timescale 1ns/1ps
`default_nettype none
module srsa_adc_model (
  input wire logic aclk,
  input wire logic fire,
  input wire logic [15:0] code_in,
  output logic valid = 1'b0,
  output logic [15:0] raw = 16'h5A5A
);
  // Word is garbage outside its valid cycle
  always @(posedge aclk) begin
    valid <= fire;
    raw <= fire ? code_in : ~raw;
  end
endmodule
`default_nettype wire

// file: test/srsa_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module srsa_top_chk
  import srsa_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic slot_a_valid,
  input wire logic slot_b_valid,
  input wire logic slot_a_result_valid,
  input wire logic slot_b_result_valid,
  input wire srsa_result_s slot_a_result,
  input wire srsa_result_s slot_b_result,
  input wire logic sample_strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Average is the sum shifted by some code 0..7
  function automatic logic avg_ok(input srsa_result_s r);
    avg_ok = 1'b0;
    for (int k = 0; k < 8; k++) begin
      if (r.avg == 16'(r.sum >> k)) avg_ok = 1'b1;
    end
  endfunction
  AST_A_LAST: assert property (
    slot_a_result_valid |-> $past(slot_a_valid)) else $error("A early");
  AST_B_LAST: assert property (
    slot_b_result_valid |-> $past(slot_b_valid)) else $error("B early");
  AST_A_AVG: assert property (
    slot_a_result_valid |-> avg_ok(slot_a_result)) else $error("A avg");
  AST_B_AVG: assert property (
    slot_b_result_valid |-> avg_ok(slot_b_result)) else $error("B avg");
  AST_A_HOLD: assert property (
    !slot_a_result_valid |-> $stable(slot_a_result)) else $error("A hold");
  AST_B_HOLD: assert property (
    !slot_b_result_valid |-> $stable(slot_b_result)) else $error("B hold");
  AST_STROBE: assert property (
    sample_strobe |=> !sample_strobe [*8]) else $error("strobe width");
  // 128 words of 16 bits never reach bit 23
  AST_B_BOUND: assert property (
    slot_b_result_valid |-> slot_b_result.sum < 27'h0800000)
    else $error("B sum range");
endmodule
bind srsa_top srsa_top_chk i_chk (
  .aclk(aclk),
  .aresetn(aresetn),
  .slot_a_valid(slot_a_valid),
  .slot_b_valid(slot_b_valid),
  .slot_a_result_valid(slot_a_result_valid),
  .slot_b_result_valid(slot_b_result_valid),
  .slot_a_result(slot_a_result),
  .slot_b_result(slot_b_result),
  .sample_strobe(sample_strobe)
);
`default_nettype wire

// file: test/sample_rate_and_slot_averager_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "srsa_regs.svh"
module sample_rate_and_slot_averager_tb;
  import srsa_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] aw = '0, wd = '0, ar = '0, rd, seed = 32'h17;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic awr, wr, bv, arr, rv, stb, fa = 1'b0, fb = 1'b0, va, vb, rva, rvb;
  logic [1:0] br, rr;
  logic [15:0] da = '0, db = '0, ra, rb, off, la, lb;
  logic [26:0] ea = '0, eb = '0, ls, lbs;
  logic [2:0] code = 3'h0;
  srsa_result_s resa, resb;
  int n_mismatch = 0, checked = 0, cyc = 0, na = 0, nb = 0, en = 0, n;
  srsa_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(aw), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
    .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ar), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .slot_a_valid(va),
    .slot_a_raw(ra), .slot_b_valid(vb), .slot_b_raw(rb),
    .sample_strobe(stb), .slot_a_result_valid(rva), .slot_a_result(resa),
    .slot_b_result_valid(rvb), .slot_b_result(resb));
  srsa_adc_model i_adc_a (.aclk(aclk), .fire(fa), .code_in(da),
    .valid(va), .raw(ra));
  srsa_adc_model i_adc_b (.aclk(aclk), .fire(fb), .code_in(db),
    .valid(vb), .raw(rb));
  initial begin
    forever #5 aclk = ~aclk;
  end
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wchk(input logic [31:0] a, d, input logic [1:0] e);
    @(posedge aclk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    do begin
      @(posedge aclk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end while (!bv);
    check(32'(br), 32'(e));
    brdy <= 1'b0;
  endtask
  task automatic rchk(input logic [31:0] a, d, input logic [1:0] e);
    @(posedge aclk);
    ar <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    do begin
      @(posedge aclk);
      if (arv && arr) arv <= 1'b0;
    end while (!rv);
    check(rd, d);
    check(32'(rr), 32'(e));
    rrdy <= 1'b0;
  endtask
  // Random one-cycle gaps make the converter slow at times
  task automatic group(input int cnt, input logic keep);
    logic [15:0] x, y;
    for (int i = 0; i < cnt; i++) begin
      x = 16'(xs());
      y = 16'(xs());
      @(posedge aclk);
      fa <= 1'b1;
      fb <= 1'b1;
      da <= x;
      db <= y;
      if (keep) begin
        ea += 27'(16'(x - off));
        eb += 27'(y);
      end
      if (xs() & 32'h1) begin
        @(posedge aclk);
        fa <= 1'b0;
        fb <= 1'b0;
      end
    end
    @(posedge aclk);
    fa <= 1'b0;
    fb <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  task automatic wait_stb();
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!stb && n < 30000);
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (aresetn && rva) begin
      check(32'(resa.sum), 32'(ea));
      check(32'(resa.avg), 32'(16'(ea >> code)));
      la = 16'(ea >> code);
      ls = ea;
      ea = '0;
      na++;
    end
    if (aresetn && rvb) begin
      check(32'(resb.sum), 32'(eb));
      check(32'(resb.avg), 32'(16'(eb >> code)));
      lb = 16'(eb >> code);
      lbs = eb;
      eb = '0;
      nb++;
    end
    if (cyc == 60000) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    off = 16'h2000;
    rchk(32'h48, 32'h28, 2'b00);
    wchk(32'h48, 32'h1, 2'b00);
    rchk(32'h54, 32'h600, 2'b00);
    rchk(32'h60, 32'h2000, 2'b00);
    rchk(32'h4, 32'h0, 2'b10);
    wait_stb();
    wait_stb();
    check(32'(n), 32'(4 * `SRSA_TB_CYCLES));
    off = 16'(xs());
    wchk(32'h60, {16'h0, off}, 2'b00);
    for (int c = 0; c < 8; c++) begin
      if (c > 1) group(1, 1'b0);
      code = 3'(c);
      wchk(32'h54, {21'h0, code, 1'b0, code, 4'h0}, 2'b00);
      group(1 << c, 1'b1);
      group(1 << c, 1'b1);
      en += 2;
      check(32'(na), 32'(en));
      check(32'(nb), 32'(en));
    end
    rchk(32'h190, {16'h0, la}, 2'b00);
    rchk(32'h180, {16'h0, la}, 2'b00);
    rchk(32'h1C0, {16'h0, ls[15:0]}, 2'b00);
    rchk(32'h1D0, {21'h0, ls[26:16]}, 2'b00);
    rchk(32'h1A0, {16'h0, lb}, 2'b00);
    rchk(32'h1E0, {16'h0, lbs[15:0]}, 2'b00);
    rchk(32'h1F0, {21'h0, lbs[26:16]}, 2'b00);
    rchk(32'h100, 32'h3, 2'b00);
    // Result words are read-only
    wchk(32'h180, 32'h1, 2'b10);
    rchk(32'h180, {16'h0, la}, 2'b00);
    stop_test();
  end
endmodule
`default_nettype wire
